/* File: rtl/plc_regs.sv */
// Functional notes
// RL1: L1 exit latency reads all ones
// RL2: L0s exit latency follows common clock bit
// RL3: active-state support reads L0s only
// RL4: maximum width reads eight lanes
// RL5: maximum speed reads 2.5 Gbps code
// RL6: extended sync sends 4096 FTS, 1024 TS1
// RL7: common clock bit software set, resets zero
// RL8: control codes 01/11 allow L0s entry
// RL9: trained width encoded x1, x4, x8
// RL10: trained speed reads 0001b
// RL11: status default follows trained width
// RL12: read-only writes ignored, reserved reads zero
//
// Local design decision: the APB slave port.
module plc_regs
  import plc_pkg::*;
#(
  parameter logic [OS_CNT_W-1:0] N_FTS = 13'h0080 // normal fts count
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic width_valid_i,
  input wire logic [5:0] trained_width_i,
  input wire logic l0s_cond_i,
  input wire logic l0s_exit_req_i,
  input wire logic l1_exit_req_i,
  input wire logic os_sent_i,
  output logic l0s_enter_o,
  output logic send_fts_o,
  output logic send_ts1_o,
  output logic enter_l0_o,
  output logic common_clock_o,
  output logic ext_sync_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    plc_st_e st; // power sequencer state
    logic [15:0] ctl; // link control contents
    logic [5:0] width; // captured trained width
    logic [31:0] rdata; // read data for the access phase
    logic l0s_enter; // one-cycle l0s entry pulse
    logic enter_l0; // one-cycle back-in-l0 pulse
  } plc_regs_s;

  plc_regs_s q;
  plc_regs_s d;

  logic setup_rd; // read setup cycle
  logic wr; // write access edge
  logic [2:0] sel; // one-hot register select
  logic [31:0] cap_word; // live capabilities value
  logic [31:0] ctl_word; // control as read
  logic [31:0] sts_word; // status as read
  logic [2:0] l0s_lat; // exit latency for current clocking
  logic aspm_en; // l0s entry allowed
  logic width_ok; // trained width is a legal code
  logic fts_load; // start an fts burst
  logic ts1_load; // start a ts1 burst
  logic [OS_CNT_W-1:0] fts_val; // fts sets for this exit
  logic [OS_CNT_W-1:0] fts_cnt; // fts sets remaining
  logic [OS_CNT_W-1:0] ts1_cnt; // ts1 sets remaining
  logic fts_last; // last fts going out
  logic ts1_last; // last ts1 going out

  // ---------------------------------------------------------------
  // bus slave and ordered set counters
  // ---------------------------------------------------------------
  plc_apb_slv u_apb (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .setup_rd_o(setup_rd),
    .wr_o(wr),
    .sel_o(sel),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o)
  );

  plc_os_cnt u_fts_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .load_i(fts_load),
    .val_i(fts_val),
    .dec_i(os_sent_i & (q.st == ST_FTS)),
    .cnt_o(fts_cnt),
    .last_o(fts_last)
  );

  plc_os_cnt u_ts1_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .load_i(ts1_load),
    .val_i(TS1_EXT_CNT),
    .dec_i(os_sent_i & (q.st == ST_TS1)),
    .cnt_o(ts1_cnt),
    .last_o(ts1_last)
  );

  // ---------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------
  always_comb
  begin
    // latency tracks the common clock bit on every rewrite
    l0s_lat = q.ctl[COMMON_CLK_BIT] ? L0S_LAT_COMMON : L0S_LAT_ASYNC; // [RL2]
    cap_word = 32'h0; // reserved upper bits read zero [RL12]
    cap_word[L1_LAT_LSB +: 3] = L1_LAT_VAL; // [RL1]
    cap_word[L0S_LAT_LSB +: 3] = l0s_lat; // [RL2]
    cap_word[ASPM_SUP_LSB +: 2] = ASPM_SUP_VAL; // [RL3]
    cap_word[MAX_WIDTH_LSB +: 6] = MAX_WIDTH_VAL; // [RL4]
    cap_word[MAX_SPEED_LSB +: 4] = MAX_SPEED_VAL; // [RL5]
    // only writable bits are ever stored
    ctl_word = {16'h0, q.ctl & LINK_CTL_WR_MASK}; // [RL12]
    sts_word = 32'h0;
    sts_word[TRAINED_WIDTH_LSB +: 6] = q.width; // [RL9] [RL11]
    sts_word[3:0] = TRAINED_SPEED_VAL; // [RL10]
  end

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  always_comb
  begin
    // low code bit set means entry allowed
    aspm_en = q.ctl[ASPM_CTL_LSB]; // [RL8]
    width_ok = (trained_width_i == WIDTH_X1) || (trained_width_i == WIDTH_X4) ||
      (trained_width_i == WIDTH_X8); // [RL9]
    fts_val = q.ctl[EXT_SYNC_BIT] ? FTS_EXT_CNT : N_FTS; // [RL6]
    fts_load = (q.st == ST_L0S) && l0s_exit_req_i;
    ts1_load = ((q.st == ST_L0) || (q.st == ST_L0S)) && l1_exit_req_i &&
      q.ctl[EXT_SYNC_BIT] && !fts_load; // [RL6]
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.l0s_enter = 1'b0;
    d.enter_l0 = 1'b0;
    // read data sampled in setup, shown in access phase
    if (setup_rd)
    begin
      case (sel)
        3'b001: d.rdata = cap_word;
        3'b010: d.rdata = ctl_word;
        3'b100: d.rdata = sts_word;
        default: d.rdata = 32'h0; // unmapped reads zero
      endcase
    end
    // only the low control byte holds writable bits
    if (wr && sel[1] && pstrb_i[0])
    begin
      d.ctl[7:0] = pwdata_i[7:0] & LINK_CTL_WR_MASK[7:0]; // [RL7] [RL12]
    end
    // capture width when training reports a legal code
    if (width_valid_i && width_ok)
    begin
      d.width = trained_width_i; // [RL11]
    end
    // link power sequencer
    case (q.st)
      ST_L0:
      begin
        if (ts1_load)
        begin
          d.st = ST_TS1; // extra ts1 on l1 exit [RL6]
        end
        else if (l1_exit_req_i)
        begin
          d.enter_l0 = 1'b1;
        end
        else if (aspm_en && l0s_cond_i)
        begin
          d.st = ST_L0S; // [RL8]
          d.l0s_enter = 1'b1;
        end
      end
      ST_L0S:
      begin
        if (fts_load)
        begin
          d.st = ST_FTS; // [RL6]
        end
        else if (ts1_load)
        begin
          d.st = ST_TS1;
        end
        else if (l1_exit_req_i)
        begin
          d.st = ST_L0;
          d.enter_l0 = 1'b1;
        end
      end
      ST_FTS:
      begin
        if (fts_last)
        begin
          d.st = ST_L0;
          d.enter_l0 = 1'b1;
        end
      end
      ST_TS1:
      begin
        if (ts1_last)
        begin
          d.st = ST_L0;
          d.enter_l0 = 1'b1;
        end
      end
      default:
      begin
        d.st = ST_L0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      q.st <= ST_L0;
      q.ctl <= LINK_CTL_RESET; // [RL7]
      q.width <= LINK_STS_RESET[TRAINED_WIDTH_LSB +: 6];
      q.rdata <= 32'h0;
      q.l0s_enter <= 1'b0;
      q.enter_l0 <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o = q.rdata;
  assign l0s_enter_o = q.l0s_enter;
  assign enter_l0_o = q.enter_l0;
  assign send_fts_o = (q.st == ST_FTS);
  assign send_ts1_o = (q.st == ST_TS1);
  assign common_clock_o = q.ctl[COMMON_CLK_BIT];
  assign ext_sync_o = q.ctl[EXT_SYNC_BIT];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  logic rd_cap; // capabilities read completes
  logic rd_sts; // status read completes
  assign rd_cap = pready_o && !pwrite_i && sel[0];
  assign rd_sts = pready_o && !pwrite_i && sel[2];

  AST_L1_LAT: assert property ( // [RL1]
    rd_cap |-> prdata_o[L1_LAT_LSB +: 3] == L1_LAT_VAL)
    else $error("l1 exit latency not all ones");

  AST_L0S_LAT: assert property ( // [RL2]
    rd_cap |-> prdata_o[L0S_LAT_LSB +: 3] == (common_clock_o ? L0S_LAT_COMMON : L0S_LAT_ASYNC))
    else $error("l0s exit latency does not follow common clock");

  AST_CAP_CONST: assert property ( // [RL3] [RL4] [RL5]
    rd_cap && !common_clock_o |->
    prdata_o == {14'h0, L1_LAT_VAL, L0S_LAT_ASYNC, ASPM_SUP_VAL, MAX_WIDTH_VAL, MAX_SPEED_VAL})
    else $error("capability constants wrong");

  AST_EXT_FTS: assert property ( // [RL6]
    (q.st == ST_L0S) && l0s_exit_req_i && ext_sync_o |=>
    send_fts_o && (fts_cnt == FTS_EXT_CNT))
    else $error("extended sync fts count wrong");

  AST_CCC_WRITE: assert property ( // [RL7]
    wr && sel[1] && pstrb_i[0] |=> common_clock_o == $past(pwdata_i[COMMON_CLK_BIT]))
    else $error("common clock bit not written");

  AST_L0S_GATE: assert property ( // [RL8]
    (q.st == ST_L0) && l0s_cond_i && !l1_exit_req_i |=>
    l0s_enter_o == $past(q.ctl[ASPM_CTL_LSB]))
    else $error("l0s entry not gated by control code");

  AST_STS_WORD: assert property ( // [RL9] [RL10] [RL11]
    rd_sts |-> prdata_o inside {32'h00000001, 32'h00000041, 32'h00000081})
    else $error("status value illegal");

  AST_WIDTH_TRACK: assert property ( // [RL11]
    width_valid_i && (trained_width_i == WIDTH_X4) ##1 !width_valid_i ##1
    (psel_i && !pwrite_i && sel[2] && !width_valid_i)[*2] |-> prdata_o[15:0] == 16'h0041)
    else $error("status default does not follow width");

  AST_RO_WRITE: assert property ( // [RL12]
    wr && !sel[1] |=> $stable(q.ctl) && (ctl_word[31:8] == 24'h0) && (ctl_word[5:2] == 4'h0))
    else $error("read-only write changed control");

  // sequencer entry and exit checks
  AST_FTS_NORMAL: assert property ( // [RL6]
    (q.st == ST_L0S) && l0s_exit_req_i && !ext_sync_o |=> send_fts_o && (fts_cnt == N_FTS))
    else $error("normal fts count wrong");

  AST_TS1_EXT: assert property ( // [RL6]
    (q.st == ST_L0) && l1_exit_req_i && ext_sync_o |=> send_ts1_o && (ts1_cnt == TS1_EXT_CNT))
    else $error("extended sync ts1 count wrong");

  AST_L1_PLAIN: assert property ( // [RL6]
    (q.st == ST_L0) && l1_exit_req_i && !ext_sync_o |=> enter_l0_o && !send_ts1_o)
    else $error("plain l1 exit did not return to l0");

  AST_L0S_ENTRY: assert property ( // [RL8]
    l0s_enter_o |-> (q.st == ST_L0S) && $past(q.ctl[ASPM_CTL_LSB]))
    else $error("l0s entered while blocked");

  AST_FTS_END: assert property ( // [RL6]
    send_fts_o && fts_last |=> enter_l0_o && !send_fts_o)
    else $error("fts burst did not end in l0");

  // main scenarios reached
  CVR_WIDTH_X8: cover property (width_valid_i && (trained_width_i == WIDTH_X8));
  CVR_L0S_ENTRY: cover property (l0s_enter_o);
  CVR_FTS_DONE: cover property (send_fts_o && fts_last && ext_sync_o);
  CVR_TS1_DONE: cover property (send_ts1_o ##1 enter_l0_o);
  CVR_CTL_WRITE: cover property (wr && sel[1] && pwdata_i[COMMON_CLK_BIT]);

endmodule : plc_regs

/* File: rtl/plc_pkg.sv */
package plc_pkg;

  // ---------------------------------------------------------------
  // register map: printed offsets are indices, byte address is 4x
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] LINK_CAP_IDX = 10'h050;
  localparam logic [9:0] LINK_CTL_IDX = 10'h054;
  localparam logic [9:0] LINK_STS_IDX = 10'h056;

  // ---------------------------------------------------------------
  // link capabilities fields
  // ---------------------------------------------------------------
  localparam int L1_LAT_LSB = 15;
  localparam int L0S_LAT_LSB = 12;
  localparam int ASPM_SUP_LSB = 10;
  localparam int MAX_WIDTH_LSB = 4;
  localparam int MAX_SPEED_LSB = 0;
  localparam logic [2:0] L1_LAT_VAL = 3'h7;
  localparam logic [2:0] L0S_LAT_ASYNC = 3'h6;
  localparam logic [2:0] L0S_LAT_COMMON = 3'h2;
  localparam logic [1:0] ASPM_SUP_VAL = 2'h1;
  localparam logic [5:0] MAX_WIDTH_VAL = 6'h08;
  localparam logic [3:0] MAX_SPEED_VAL = 4'h1;
  localparam logic [31:0] LINK_CAP_RESET = 32'h000B0211;

  // ---------------------------------------------------------------
  // link control fields
  // ---------------------------------------------------------------
  localparam int EXT_SYNC_BIT = 7;
  localparam int COMMON_CLK_BIT = 6;
  localparam int ASPM_CTL_LSB = 0;
  localparam logic [15:0] LINK_CTL_WR_MASK = 16'h00C3;
  localparam logic [15:0] LINK_CTL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // link status fields
  // ---------------------------------------------------------------
  localparam int TRAINED_WIDTH_LSB = 4;
  localparam logic [3:0] TRAINED_SPEED_VAL = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h00;
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;
  localparam logic [15:0] LINK_STS_RESET = 16'h0001;

  // ---------------------------------------------------------------
  // ordered set counts
  // ---------------------------------------------------------------
  localparam int OS_CNT_W = 13;
  localparam logic [12:0] FTS_EXT_CNT = 13'h1000;
  localparam logic [12:0] TS1_EXT_CNT = 13'h0400;

  // link power sequencer states
  typedef enum logic [1:0] {
    ST_L0 = 2'b00,
    ST_FTS = 2'b01,
    ST_TS1 = 2'b10,
    ST_L0S = 2'b11
  } plc_st_e;

endpackage : plc_pkg

/* File: rtl/plc_apb_slv.sv */
// apb decode: strobes, one-hot select, ready and error
module plc_apb_slv
  import plc_pkg::*;
(
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  output logic setup_rd_o,
  output logic wr_o,
  output logic [2:0] sel_o,
  output logic pready_o,
  output logic pslverr_o
);

  logic [9:0] idx; // word index of the access
  logic access; // access phase of any transfer

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb
  begin
    idx = paddr_i[ADDR_W-1:2];
    access = psel_i & penable_i;
    sel_o = 3'h0;
    // misaligned addresses hit nothing
    if (paddr_i[1:0] == 2'h0)
    begin
      sel_o[0] = (idx == LINK_CAP_IDX);
      sel_o[1] = (idx == LINK_CTL_IDX);
      sel_o[2] = (idx == LINK_STS_IDX);
    end
    // zero wait states: ready in every access phase
    pready_o = access;
    pslverr_o = access & (sel_o == 3'h0);
    setup_rd_o = psel_i & ~penable_i & ~pwrite_i;
    wr_o = access & pwrite_i;
  end

endmodule : plc_apb_slv

/* File: rtl/plc_os_cnt.sv */
// ordered set down counter with last-set flag
module plc_os_cnt
  import plc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic [OS_CNT_W-1:0] val_i,
  input wire logic dec_i,
  output logic [OS_CNT_W-1:0] cnt_o,
  output logic last_o
);

  typedef struct packed {
    logic [OS_CNT_W-1:0] cnt; // sets still to send
  } plc_cnt_s;

  plc_cnt_s st_q;
  plc_cnt_s st_d;

  // ---------------------------------------------------------------
  // next state: load wins over decrement
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (load_i)
    begin
      st_d.cnt = val_i;
    end
    else if (dec_i && (st_q.cnt != '0))
    begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cnt_o = st_q.cnt;
  // last set goes out this cycle
  assign last_o = dec_i & ~load_i & (st_q.cnt == {{(OS_CNT_W-1){1'b0}}, 1'b1});

  AST_CNT_LOAD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [RL6]
    load_i |=> (cnt_o == $past(val_i)))
    else $error("counter did not take load value");

endmodule : plc_os_cnt

/* File: dv/plc_link_model.sv */
// far side: sends one ordered set per granted cycle
module plc_link_model
(
  input wire logic clk_sys_i,
  input wire logic send_fts_i,
  input wire logic send_ts1_i,
  input wire logic slow_i,
  output logic os_sent_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gap_q = 1'b0; // slow mode skips every other cycle
  initial os_sent_o = 1'b0;

  // --------------------------------
  // ordered set emission
  // --------------------------------
  always @(posedge clk_sys_i)
  begin
    gap_q <= ~gap_q;
    os_sent_o <= (send_fts_i | send_ts1_i) & (~slow_i | gap_q);
  end
endmodule : plc_link_model

/* File: dv/tb.sv */
module tb
  import plc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------
  // signals
  // --------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic [3:0] pstrb = '0, s;
  logic pready, pslverr, os_sent, l0s_enter, send_fts, send_ts1, enter_l0, cc, es;
  logic width_valid = 1'b0, l0s_cond = 1'b0, l0s_exit = 1'b0, l1_exit = 1'b0, slow = 1'b0;
  logic [5:0] trained_width = '0, w_exp = '0;
  logic [5:0] wl [4] = '{6'h04, 6'h08, 6'h03, 6'h00}; // last legal, one illegal
  logic [15:0] ctl_exp = '0;
  logic [32:0] rd_q [$]; // expected {error, data} per read
  int os_q [$]; // expected ordered set count per return to L0
  int err_count = 0, tests_run = 0, cyc = 0, os_cnt = 0, l0s_cnt = 0, l0s_exp = 0;
  int seed = 69329;

  always #2 clk_sys = ~clk_sys;

  plc_regs #(.N_FTS(13'h0004)) DUT (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .width_valid_i(width_valid), .trained_width_i(trained_width), .l0s_cond_i(l0s_cond),
    .l0s_exit_req_i(l0s_exit), .l1_exit_req_i(l1_exit), .os_sent_i(os_sent),
    .l0s_enter_o(l0s_enter), .send_fts_o(send_fts), .send_ts1_o(send_ts1),
    .enter_l0_o(enter_l0), .common_clock_o(cc), .ext_sync_o(es));

  plc_link_model far_end (.clk_sys_i(clk_sys), .send_fts_i(send_fts), .send_ts1_i(send_ts1),
    .slow_i(slow), .os_sent_o(os_sent));

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // one apb transfer; reads note their expectation first
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st, input logic [32:0] exp);
    int n;
    n = 0;
    if (!wr)
      rd_q.push_back(exp);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n == 16)
      err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle request: 0 l0s condition, 1 l0s exit, 2 l1 exit
  task automatic pulse(input int k);
    @(posedge clk_sys);
    if (k == 0) l0s_cond <= 1'b1;
    if (k == 1) l0s_exit <= 1'b1;
    if (k == 2) l1_exit <= 1'b1;
    @(posedge clk_sys);
    l0s_cond <= 1'b0;
    l0s_exit <= 1'b0;
    l1_exit <= 1'b0;
  endtask : pulse

  // bounded wait for the return to L0, noting the set count
  task automatic back_to_l0(input int k, input int sets);
    int n;
    n = 0;
    os_q.push_back(sets);
    pulse(k);
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (enter_l0 !== 1'b1 && n < 20000);
    if (n == 20000)
      err_count++;
  endtask : back_to_l0

  function automatic logic [32:0] cap_exp(input logic c);
    return {15'h0, L1_LAT_VAL, c ? L0S_LAT_COMMON : L0S_LAT_ASYNC, ASPM_SUP_VAL,
            MAX_WIDTH_VAL, MAX_SPEED_VAL};
  endfunction : cap_exp

  // --------------------------------
  // watcher: compares results as they appear
  // --------------------------------
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      summarize();
    end
    if ((send_fts === 1'b1 || send_ts1 === 1'b1) && os_sent)
      os_cnt++;
    if (l0s_enter === 1'b1)
      l0s_cnt++;
    if (enter_l0 === 1'b1)
    begin
      check("ordered_sets", os_cnt, os_q.pop_front());
      os_cnt = 0;
    end
    if (psel && penable && !pwrite && pready === 1'b1)
      check("read", {pslverr, prdata}, rd_q.pop_front());
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(0, 12'h140, 0, 4'hF, cap_exp(1'b0));
    apb(0, 12'h150, 0, 4'hF, 33'h0);
    apb(0, 12'h158, 0, 4'hF, 33'h1);
    for (int i = 0; i < 8; i++)
    begin
      d = $random(seed);
      s = $random(seed);
      if (s[0])
        ctl_exp = d[15:0] & LINK_CTL_WR_MASK;
      apb(1, 12'h150, d, s, 33'h0);
      apb(0, 12'h150, 0, 4'hF, {17'h0, ctl_exp});
      apb(0, 12'h140, 0, 4'hF, cap_exp(ctl_exp[COMMON_CLK_BIT]));
      check("common_clock", cc, ctl_exp[COMMON_CLK_BIT]);
    end
    apb(1, 12'h140, '1, 4'hF, 33'h0);
    apb(1, 12'h158, '1, 4'hF, 33'h0);
    apb(1, 12'h15C, '1, 4'hF, 33'h0);
    apb(0, 12'h140, 0, 4'hF, cap_exp(ctl_exp[COMMON_CLK_BIT]));
    apb(0, 12'h158, 0, 4'hF, 33'h1);
    apb(0, 12'h15C, 0, 4'hF, {1'b1, 32'h0});
    apb(0, 12'h151, 0, 4'hF, {1'b1, 32'h0});
    foreach (wl[i])
    begin
      @(posedge clk_sys);
      width_valid <= 1'b1;
      trained_width <= wl[i];
      @(posedge clk_sys);
      width_valid <= 1'b0;
      if (wl[i] != 6'h03)
        w_exp = wl[i];
      apb(0, 12'h158, 0, 4'hF, {23'h0, w_exp, TRAINED_SPEED_VAL});
    end
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 12'h150, c, 4'hF, 33'h0);
      pulse(0);
      repeat (3) @(posedge clk_sys);
      if (c[0])
        l0s_exp++;
      check("l0s_entries", l0s_cnt, l0s_exp);
      if (c[0])
        back_to_l0(1, 4);
    end
    apb(1, 12'h150, 32'h81, 4'hF, 33'h0);
    @(posedge clk_sys);
    check("ext_sync", es, 1'b1);
    slow <= 1'b1;
    pulse(0);
    back_to_l0(1, 4096);
    back_to_l0(2, 1024);
    apb(1, 12'h150, 32'h0, 4'hF, 33'h0);
    back_to_l0(2, 0);
    repeat (4) @(posedge clk_sys);
    summarize();
  end
endmodule : tb
